/* rtl/pmctl_pkg.sv */
package pmctl_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int AW = 8;
  localparam int DW = 32;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] PMCSR_OFS     = 8'hc4;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'hc8;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'hcc;
  localparam logic [7:0] CMD_OFS       = 8'hd0;
  localparam logic [7:0] WAKE_CTL_OFS  = 8'hd4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int WES_BIT    = 15;
  localparam int SCALE_HI   = 14;
  localparam int SCALE_LO   = 13;
  localparam int SEL_HI     = 12;
  localparam int SEL_LO     = 9;
  localparam int WAE_BIT    = 8;
  localparam int PWR_HI     = 1;
  localparam int PWR_LO     = 0;
  localparam int CMD_B18    = 18;
  localparam int CMD_B19    = 19;
  localparam int MAGIC_BIT  = 9;
  localparam int LINE_BIT   = 31;
  localparam int IRQ_WAKE   = 0;
  localparam int IRQ_PWR    = 1;
  localparam int IRQ_RESUME = 2;
  localparam int IRQ_N      = 3;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [31:0]      PMCSR_RST   = 32'h0000_0000;
  localparam logic [31:0]      PMCSR_WMASK = 32'h0000_9f03;
  localparam logic [IRQ_N-1:0] IRQ_RST     = 3'h0;
  localparam logic [3:0]       SEL_RST     = 4'h0;
  localparam logic [1:0]       SCALE_VAL   = 2'h0;

  // ****************************************
  // Power states
  // ****************************************
  typedef enum logic [1:0] {
    PMCTL_D0,
    PMCTL_D1,
    PMCTL_D2,
    PMCTL_D3HOT
  } pmctl_pstate_t;

  // Byte-lane merge of a write
  function automatic logic [31:0] pmctl_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* rtl/pmctl_regif_if.sv */
interface pmctl_regif_if;
  import pmctl_pkg::*;

  logic          wr_fire;
  logic          rd_req;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [3:0]    be;
  logic [DW-1:0] rdata;

  modport slave_side (output wr_fire, output rd_req, output addr, output wdata,
                      output be, input rdata);
  modport core_side  (input wr_fire, input rd_req, input addr, input wdata,
                      input be, output rdata);
endinterface

/* rtl/pmctl_bus_slave.sv */
module pmctl_bus_slave
  import pmctl_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Avalon-MM slave
  input  wire logic [AW-1:0] avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [DW-1:0] avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [DW-1:0] avs_readdata,
  output logic               avs_waitrequest,
  // Core side
  pmctl_regif_if.slave_side  rif
);

  logic          wait_q;
  logic [DW-1:0] rdata_q;

  // ****************************************
  // One wait state handshake
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (rif.rd_req) begin
      rdata_q <= rif.rdata;
    end
  end

  assign rif.rd_req        = avs_read && wait_q;
  assign rif.wr_fire       = avs_write && !wait_q;
  assign rif.addr          = avs_address;
  assign rif.wdata         = avs_writedata;
  assign rif.be            = avs_byteenable;
  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;

endmodule

/* rtl/pmctl_irq.sv */
module pmctl_irq
  import pmctl_pkg::*;
#(
  parameter int N = IRQ_N
)(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Events and software access
  input  wire logic [N-1:0] event_i,
  input  wire logic         clr_wr,
  input  wire logic [N-1:0] clr_mask,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_val,
  // State
  output logic      [N-1:0] stat_q,
  output logic      [N-1:0] mask_q,
  output logic              irq_q
);

  // ****************************************
  // Sticky status, set wins over clear
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_q <= N'(IRQ_RST);
    end else begin
      stat_q <= (stat_q & ~(clr_wr ? clr_mask : '0)) | event_i;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_q <= N'(IRQ_RST);
    end else if (mask_wr) begin
      mask_q <= mask_val;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

endmodule

/* rtl/pmctl_top.sv */
// How it works
// - Wake event sets status regardless of enable
// - Writing one clears status; zero keeps it
// - Enable bit gates the wake request pin
// - Both command bits force magic-packet wake enable
// - Power field reads state, write sets it
// - Power resume returns field to D0
// - Data scale field is read-only zero
// - Data select is plain read/write storage
// - Register at c4, resets to all zero
module pmctl_top
  import pmctl_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Avalon-MM slave
  input  wire logic [AW-1:0] avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [DW-1:0] avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [DW-1:0] avs_readdata,
  output logic               avs_waitrequest,
  // Device events
  input  wire logic          wake_event,
  input  wire logic          power_resume,
  // Wake request pin, open drain, active low
  input  wire logic          pme_n_i,
  output logic               pme_n_o,
  output logic               pme_oe,
  // Power state and interrupt
  output logic      [1:0]    power_state,
  output logic               magic_wake_en,
  output logic               irq
);

  pmctl_regif_if rif ();

  logic            wes_q;
  logic            wae_q;
  logic [3:0]      sel_q;
  pmctl_pstate_t   pstate_q;
  logic [31:0]     cmd_q;
  logic            magic_q;
  logic            line_q;
  logic            pme_oe_q;
  logic [IRQ_N-1:0] istat;
  logic [IRQ_N-1:0] imask;
  logic            irq_q;
  logic [31:0]     pmcsr_rd;
  logic [31:0]     pm_new;
  logic [31:0]     cmd_new;
  logic [31:0]     wctl_new;
  logic            wr_pm;
  logic            wr_cmd;
  logic            wr_wctl;
  logic            wr_istat;
  logic            wr_imask;
  logic            pwr_wr;
  logic            cmd_both;

  // ****************************************
  // Bus slave and interrupt block
  // ****************************************
  pmctl_bus_slave u_slave (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rif             (rif)
  );

  pmctl_irq #(.N(IRQ_N)) u_irq (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .event_i  ({power_resume, pwr_wr, wake_event}),
    .clr_wr   (wr_istat),
    .clr_mask (rif.wdata[IRQ_N-1:0]),
    .mask_wr  (wr_imask),
    .mask_val (rif.wdata[IRQ_N-1:0]),
    .stat_q   (istat),
    .mask_q   (imask),
    .irq_q    (irq_q)
  );

  // ****************************************
  // Address decode
  // ****************************************
  // Register placed at c4
  // Offset decode
  assign wr_pm    = rif.wr_fire && (rif.addr == PMCSR_OFS);
  assign wr_cmd   = rif.wr_fire && (rif.addr == CMD_OFS);
  assign wr_wctl  = rif.wr_fire && (rif.addr == WAKE_CTL_OFS);
  assign wr_istat = rif.wr_fire && (rif.addr == IRQ_STAT_OFS) && rif.be[0];
  assign wr_imask = rif.wr_fire && (rif.addr == IRQ_MASK_OFS) && rif.be[0];

  assign pm_new   = pmctl_merge(pmcsr_rd, rif.wdata, rif.be) & PMCSR_WMASK;
  assign cmd_new  = pmctl_merge(cmd_q, rif.wdata, rif.be);
  assign wctl_new = pmctl_merge({31'h0, magic_q} << MAGIC_BIT, rif.wdata, rif.be);
  assign pwr_wr   = wr_pm && rif.be[0];
  assign cmd_both = cmd_q[CMD_B18] && cmd_q[CMD_B19];

  // ****************************************
  // Wake event status
  // ****************************************
  // Set wins over write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wes_q <= PMCSR_RST[WES_BIT];
    end else if (wake_event) begin
      wes_q <= 1'b1;
    end else if (wr_pm && rif.be[1] && rif.wdata[WES_BIT]) begin
      wes_q <= 1'b0;
    end
  end

  // ****************************************
  // Wake enable and data select
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wae_q <= PMCSR_RST[WAE_BIT];
    end else if (wr_pm) begin
      wae_q <= pm_new[WAE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_q <= SEL_RST;
    end else if (wr_pm) begin
      sel_q <= pm_new[SEL_HI:SEL_LO];
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  // Resume wins over write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pstate_q <= PMCTL_D0;
    end else if (power_resume) begin
      pstate_q <= PMCTL_D0;
    end else if (pwr_wr) begin
      case (pm_new[PWR_HI:PWR_LO])
        2'h0:    pstate_q <= PMCTL_D0;
        2'h1:    pstate_q <= PMCTL_D1;
        2'h2:    pstate_q <= PMCTL_D2;
        2'h3:    pstate_q <= PMCTL_D3HOT;
        default: pstate_q <= PMCTL_D0;
      endcase
    end
  end

  // ****************************************
  // Command and wake control
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_q <= 32'h0000_0000;
    end else if (wr_cmd) begin
      cmd_q <= cmd_new;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      magic_q <= 1'b0;
    end else if (cmd_both) begin
      magic_q <= 1'b1;
    end else if (wr_wctl) begin
      magic_q <= wctl_new[MAGIC_BIT];
    end
  end

  // ****************************************
  // Wake request pin
  // ****************************************
  // Enable gates assertion
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pme_oe_q <= 1'b0;
      line_q   <= 1'b1;
    end else begin
      pme_oe_q <= wes_q && wae_q;
      line_q   <= pme_n_i;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Fixed zero fields
  always_comb begin
    pmcsr_rd                    = 32'h0000_0000;
    pmcsr_rd[WES_BIT]           = wes_q;
    pmcsr_rd[SCALE_HI:SCALE_LO] = SCALE_VAL;
    pmcsr_rd[SEL_HI:SEL_LO]     = sel_q;
    pmcsr_rd[WAE_BIT]           = wae_q;
    pmcsr_rd[PWR_HI:PWR_LO]     = pstate_q;
  end

  always_comb begin
    case (rif.addr)
      PMCSR_OFS:    rif.rdata = pmcsr_rd;
      IRQ_STAT_OFS: rif.rdata = {{(DW-IRQ_N){1'b0}}, istat};
      IRQ_MASK_OFS: rif.rdata = {{(DW-IRQ_N){1'b0}}, imask};
      CMD_OFS:      rif.rdata = cmd_q;
      WAKE_CTL_OFS: rif.rdata = ({31'h0, line_q} << LINE_BIT)
                               | ({31'h0, magic_q} << MAGIC_BIT);
      default:      rif.rdata = 32'h0000_0000;
    endcase
  end

  assign pme_n_o       = 1'b0;
  assign pme_oe        = pme_oe_q;
  assign power_state   = pstate_q;
  assign magic_wake_en = magic_q;
  assign irq           = irq_q;

  // ****************************************
  // Checks
  // ****************************************
  logic rd_pm_done;
  assign rd_pm_done = avs_read && !avs_waitrequest && (avs_address == PMCSR_OFS);

  property p_wes_set;
    @(posedge mclk) disable iff (!rst_n)
      wake_event |=> wes_q;
  endproperty
  a_wes_set: assert property (p_wes_set)
    else $error("wake event did not set status");

  property p_wes_clr;
    @(posedge mclk) disable iff (!rst_n)
      (wr_pm && rif.be[1] && rif.wdata[WES_BIT] && !wake_event) |=> !wes_q ##1 !pme_oe;
  endproperty
  a_wes_clr: assert property (p_wes_clr)
    else $error("write one did not clear status and pin");

  property p_wes_keep;
    @(posedge mclk) disable iff (!rst_n)
      (wes_q && !(wr_pm && rif.be[1] && rif.wdata[WES_BIT])) |=> wes_q;
  endproperty
  a_wes_keep: assert property (p_wes_keep)
    else $error("status lost without write one");

  property p_pin_gate;
    @(posedge mclk) disable iff (!rst_n)
      (wes_q && wae_q) |=> pme_oe;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("wake pin not driven for enabled status");

  property p_pin_off;
    @(posedge mclk) disable iff (!rst_n)
      !wae_q |=> !pme_oe;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("wake pin driven while enable clear");

  property p_magic;
    @(posedge mclk) disable iff (!rst_n)
      cmd_both |=> magic_wake_en;
  endproperty
  a_magic: assert property (p_magic)
    else $error("magic wake not enabled by command bits");

  property p_pwr_write;
    @(posedge mclk) disable iff (!rst_n)
      (pwr_wr && !power_resume) |=> power_state == $past(rif.wdata[1:0]);
  endproperty
  a_pwr_write: assert property (p_pwr_write)
    else $error("power state not taken from write");

  property p_resume;
    @(posedge mclk) disable iff (!rst_n)
      power_resume |=> power_state == 2'h0;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not return to D0");

  property p_scale;
    @(posedge mclk) disable iff (!rst_n)
      rd_pm_done |-> avs_readdata[SCALE_HI:SCALE_LO] == 2'h0;
  endproperty
  a_scale: assert property (p_scale)
    else $error("data scale not zero");

  property p_select;
    @(posedge mclk) disable iff (!rst_n)
      (wr_pm && rif.be[1]) |=> sel_q == $past(rif.wdata[12:9]);
  endproperty
  a_select: assert property (p_select)
    else $error("data select not stored");

  property p_reset;
    @(posedge mclk)
      !rst_n |=> (pmcsr_rd == 32'h0000_0000) && !pme_oe;
  endproperty
  a_reset: assert property (p_reset)
    else $error("register not zero after reset");

  property p_resv;
    @(posedge mclk) disable iff (!rst_n)
      rd_pm_done |-> (avs_readdata[31:16] == 16'h0) && (avs_readdata[7:2] == 6'h0);
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits not zero");

  property p_irq;
    @(posedge mclk) disable iff (!rst_n)
      (wake_event && imask[IRQ_WAKE]) |=> ##1 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked wake event raised no interrupt");

  property p_cv_wake;
    @(posedge mclk) disable iff (!rst_n)
      wake_event && wae_q ##2 pme_oe;
  endproperty
  c_cv_wake: cover property (p_cv_wake);

  property p_cv_d3;
    @(posedge mclk) disable iff (!rst_n)
      power_state == 2'h3 ##[1:50] power_resume;
  endproperty
  c_cv_d3: cover property (p_cv_d3);

  property p_cv_clr_race;
    @(posedge mclk) disable iff (!rst_n)
      wake_event && wr_pm && rif.wdata[WES_BIT];
  endproperty
  c_cv_clr_race: cover property (p_cv_clr_race);

endmodule

/* verif/pmctl_host_model.sv */
module pmctl_host_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Wake request pin of the device
  input  wire logic       pme_oe,
  input  wire logic       pme_n_o,
  // Observed wire and requests seen
  output logic            pme_line,
  output logic      [7:0] wake_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Open-drain wire with pull-up
  // ****************************************
  logic line_q;

  assign pme_line = pme_oe ? pme_n_o : 1'b1;

  // ****************************************
  // Wake request counter
  // ****************************************
  // Count low-going requests
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_q     <= 1'b1;
      wake_count <= 8'h00;
    end else begin
      line_q <= pme_line;
      if (line_q && !pme_line) begin
        wake_count <= wake_count + 8'h01;
      end
    end
  end
endmodule

/* verif/pci_power_mgmt_control_status_test.sv */
module pci_power_mgmt_control_status_test;
  import pmctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          mclk;
  logic          rst_n;
  logic [AW-1:0] avs_address;
  logic          avs_read;
  logic          avs_write;
  logic [DW-1:0] avs_writedata;
  logic [3:0]    avs_byteenable;
  logic [DW-1:0] avs_readdata;
  logic          avs_waitrequest;
  logic          wake_event;
  logic          power_resume;
  logic          pme_line;
  logic          pme_n_o;
  logic          pme_oe;
  logic [1:0]    power_state;
  logic          magic_wake_en;
  logic          irq;
  logic [7:0]    wake_count;
  int            num_errors;
  int            compares;

  pmctl_top pmctl_top_inst (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wake_event(wake_event), .power_resume(power_resume), .pme_n_i(pme_line),
    .pme_n_o(pme_n_o), .pme_oe(pme_oe), .power_state(power_state),
    .magic_wake_en(magic_wake_en), .irq(irq)
  );

  pmctl_host_model pmctl_host_model_inst (
    .mclk(mclk), .rst_n(rst_n), .pme_oe(pme_oe), .pme_n_o(pme_n_o),
    .pme_line(pme_line), .wake_count(wake_count)
  );

  // ****************************************
  // Clock
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    check(name, q, exp);
  endtask

  task automatic pulse(input logic resume);
    @(posedge mclk);
    if (resume) begin
      power_resume <= 1'b1;
    end else begin
      wake_event <= 1'b1;
    end
    @(posedge mclk);
    power_resume <= 1'b0;
    wake_event   <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    num_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    wake_event = 1'b0;
    power_resume = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values and unmapped place
    rd("pmcsr", PMCSR_OFS, 32'h0000_0000);
    rd("irq_stat", IRQ_STAT_OFS, 32'h0000_0000);
    rd("irq_mask", IRQ_MASK_OFS, 32'h0000_0000);
    rd("cmd", CMD_OFS, 32'h0000_0000);
    rd("wake_ctl", WAKE_CTL_OFS, 32'h8000_0000);
    rd("unmapped", 8'h00, 32'h0000_0000);
    // All ones: reserved and scale stay zero
    wr(PMCSR_OFS, 32'hffff_ffff, 4'hf);
    rd("pmcsr_ones", PMCSR_OFS, 32'h0000_1f03);
    settle();
    check("irq_masked", irq, 1'b0);
    rd("irq_pwr", IRQ_STAT_OFS, 32'h0000_0002);
    wr(IRQ_STAT_OFS, 32'h0000_0007, 4'h1);
    rd("irq_clr", IRQ_STAT_OFS, 32'h0000_0000);
    // Every power state, then resume
    for (int i = 0; i < 4; i++) begin
      wr(PMCSR_OFS, 32'(i), 4'h1);
      rd("pwr_field", PMCSR_OFS, 32'h0000_1f00 | 32'(i));
      settle();
      check("power_state", power_state, 32'(i));
    end
    pulse(1'b1);
    settle();
    check("resume_state", power_state, 2'h0);
    rd("resume_field", PMCSR_OFS, 32'h0000_1f00);
    // Wake with assertion disabled
    wr(PMCSR_OFS, 32'h0000_0000, 4'hf);
    pulse(1'b0);
    settle();
    rd("wes_set", PMCSR_OFS, 32'h0000_8000);
    check("pme_off", pme_oe, 1'b0);
    check("host_none", wake_count, 8'h00);
    wr(PMCSR_OFS, 32'h0000_0000, 4'h2);
    rd("wes_keep", PMCSR_OFS, 32'h0000_8000);
    wr(PMCSR_OFS, 32'h0000_8000, 4'h2);
    rd("wes_clr", PMCSR_OFS, 32'h0000_0000);
    // Wake with assertion enabled
    wr(PMCSR_OFS, 32'h0000_0100, 4'h2);
    pulse(1'b0);
    settle();
    check("pme_on", pme_oe, 1'b1);
    check("line_low", pme_line, 1'b0);
    check("host_one", wake_count, 8'h01);
    rd("pin_low", WAKE_CTL_OFS, 32'h0000_0000);
    wr(PMCSR_OFS, 32'h0000_8100, 4'h2);
    settle();
    check("pme_rel", pme_oe, 1'b0);
    rd("pmcsr_en", PMCSR_OFS, 32'h0000_0100);
    rd("pin_high", WAKE_CTL_OFS, 32'h8000_0000);
    // Interrupt raise and clear
    wr(IRQ_STAT_OFS, 32'h0000_0007, 4'h1);
    wr(IRQ_MASK_OFS, 32'h0000_0001, 4'h1);
    pulse(1'b0);
    settle();
    check("irq_on", irq, 1'b1);
    rd("irq_wake", IRQ_STAT_OFS, 32'h0000_0001);
    wr(IRQ_STAT_OFS, 32'h0000_0001, 4'h1);
    settle();
    check("irq_off", irq, 1'b0);
    // Magic wake forced by command bits, assertion disabled
    wr(PMCSR_OFS, 32'h0000_8000, 4'hf);
    wr(CMD_OFS, 32'h000c_0000, 4'hf);
    settle();
    check("magic_on", magic_wake_en, 1'b1);
    wr(WAKE_CTL_OFS, 32'h0000_0000, 4'hf);
    rd("magic_held", WAKE_CTL_OFS, 32'h8000_0200);
    wr(CMD_OFS, 32'h0004_0000, 4'hf);
    wr(WAKE_CTL_OFS, 32'h0000_0000, 4'hf);
    settle();
    check("magic_off", magic_wake_en, 1'b0);
    rd("magic_rd", WAKE_CTL_OFS, 32'h8000_0000);
    // Reset in mid-run with pin driven
    wr(PMCSR_OFS, 32'hffff_ffff, 4'hf);
    pulse(1'b0);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd("pmcsr_rerun", PMCSR_OFS, 32'h0000_0000);
    check("pme_rerun", pme_oe, 1'b0);
    check("irq_rerun", irq, 1'b0);
    wrap_up();
  end
endmodule
